// ===== rtl/branch_cond_eval.sv
// Condition evaluator: decides whether a branch is taken or a skip happens.
// Assumes its inputs are stable through the decide cycle of the sequencer.
module branch_cond_eval
  import branch_unit_pkg::*;
(
  branch_cond_if.evaluator cond
);

  // ----------------------------------------------------------------
  // Flag and I/O bit tests
  // ----------------------------------------------------------------
  logic carry;
  logic sign_test;
  logic sel_flag;
  logic sel_io;

  assign carry = cond.status[FLAG_CARRY_POS];
  // Signed compares look at negative xor overflow, not at either alone
  assign sign_test = cond.status[FLAG_NEG_POS] ^ cond.status[FLAG_OVF_POS];
  assign sel_flag = cond.status[cond.sel];
  assign sel_io = cond.io_value[cond.sel];

  // Outcome per instruction code
  always_comb begin
    cond.taken = 1'b0;
    cond.legal = 1'b1;
    case (cond.op)
      skip_io_clear_op: cond.taken = ~sel_io;
      skip_io_set_op: cond.taken = sel_io;
      branch_flag_set_op: cond.taken = sel_flag;
      branch_flag_clear_op: cond.taken = ~sel_flag;
      branch_carry_clear_op: cond.taken = ~carry;
      branch_same_higher_op: cond.taken = ~carry;
      branch_signed_ge_op: cond.taken = ~sign_test;
      branch_signed_lt_op: cond.taken = sign_test;
      default: cond.legal = 1'b0;
    endcase
  end

endmodule : branch_cond_eval

// ===== rtl/branch_cond_if.sv
// Bundle between the sequencer and the condition evaluator.
// Assumes both ends sit in the same clock domain; the evaluator is purely combinational.
interface branch_cond_if;
  logic [3:0] op;
  logic [2:0] sel;
  logic [7:0] status;
  logic [7:0] io_value;
  logic taken;
  logic legal;

  modport requester (output op, output sel, output status, output io_value,
                     input taken, input legal);
  modport evaluator (input op, input sel, input status, input io_value,
                     output taken, output legal);
endinterface : branch_cond_if

// ===== rtl/branch_skip_unit.sv
// Conditional branch and skip unit with an Avalon-MM register port.
// Assumes the bus master follows Avalon-MM waitrequest rules and that io_reg_i is
// synchronous to clk_sys_i.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.

module branch_skip_unit
  import branch_unit_pkg::*;
#(
  parameter int PC_WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // I/O register under test
  input wire logic [7:0] io_reg_i,
  // Core view
  output logic [PC_WIDTH-1:0] pc_o,
  output logic busy_o,
  output logic taken_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (PC_WIDTH < 8 || PC_WIDTH > 32) begin : g_bad_width
      $error("PC_WIDTH must lie between 8 and 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  branch_cond_if cond ();

  state_t state;
  logic [31:0] wmask;
  logic bus_wr;
  logic bus_rd;
  logic [3:0] op_q;
  logic [2:0] sel_q;
  logic [6:0] offset_q;
  logic two_word_q;
  logic [7:0] status_register;
  logic [PC_WIDTH-1:0] pc_target;
  logic [1:0] cycles_left;
  logic [1:0] last_cycles;
  logic refused;
  logic cmd_write;
  logic cmd_accept;
  logic next_refused;
  logic [PC_WIDTH-1:0] offset_ext;
  logic [PC_WIDTH-1:0] next_target;
  logic [1:0] next_cycles;
  logic is_skip;
  logic [31:0] next_readdata;

  // ----------------------------------------------------------------
  // Condition evaluator
  // ----------------------------------------------------------------
  assign cond.op = op_q;
  assign cond.sel = sel_q;
  assign cond.status = status_register;
  assign cond.io_value = io_reg_i;

  branch_cond_eval u_eval (
    .cond(cond)
  );

  // ----------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------
  // A request is answered one cycle after it is seen; the access completes at the
  // edge where waitrequest is low, so every access costs exactly two cycles.
  assign bus_wr = write_i & ~waitrequest_o;
  assign bus_rd = read_i & waitrequest_o;   // Read seen, answer not given yet
  assign wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                  {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // Waitrequest drops for one cycle per request, then rises again
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
    end else if (!waitrequest_o) begin
      waitrequest_o <= 1'b1;
    end else if (read_i || write_i) begin
      waitrequest_o <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address_i)
      REG_CMD_OFS: begin
        next_readdata[CMD_OP_POS +: 4] = op_q;
        next_readdata[CMD_SEL_POS +: 3] = sel_q;
      end
      REG_OPERAND_OFS: begin
        next_readdata[OPND_OFFSET_POS +: 7] = offset_q;
        next_readdata[OPND_TWO_WORD_POS] = two_word_q;
      end
      REG_STATUS_OFS: next_readdata[7:0] = status_register;
      REG_PC_OFS: next_readdata[PC_WIDTH-1:0] = pc_o;
      REG_STATE_OFS: begin
        next_readdata[STATE_BUSY_POS] = busy_o;
        next_readdata[STATE_TAKEN_POS] = taken_o;
        next_readdata[STATE_REFUSED_POS] = refused;
        next_readdata[STATE_CYCLES_POS +: 2] = last_cycles;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured as waitrequest drops and stands through the taking edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      readdata_o <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Command and operand registers
  // ----------------------------------------------------------------
  assign cmd_write = bus_wr && (address_i == REG_CMD_OFS) && byteenable_i[0];
  assign cmd_accept = cmd_write && (state == ST_IDLE);

  // Instruction code and bit select are latched only when a command is accepted
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      op_q <= 4'h0;
      sel_q <= 3'h0;
    end else if (cmd_accept) begin
      op_q <= writedata_i[CMD_OP_POS +: 4];
      sel_q <= writedata_i[CMD_SEL_POS +: 3];
    end
  end

  // Operand register; frozen while an instruction is in flight
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      offset_q <= OFFSET_RESET;
      two_word_q <= 1'b0;
    end else if (bus_wr && address_i == REG_OPERAND_OFS && state == ST_IDLE) begin
      if (byteenable_i[0]) begin
        offset_q <= writedata_i[OPND_OFFSET_POS +: 7];
      end
      if (byteenable_i[1]) begin
        two_word_q <= writedata_i[OPND_TWO_WORD_POS];
      end
    end
  end

  // Flags are written by software only; no branch ever alters them
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_register <= STATUS_RESET;
    end else if (bus_wr && address_i == REG_STATUS_OFS && byteenable_i[0]
                 && state == ST_IDLE) begin
      status_register <= writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Refused-command flag
  // ----------------------------------------------------------------
  // A command while busy, or an unknown code, sets the flag; writing one to it
  // in the state register clears it, but a new refusal in that cycle wins.
  always_comb begin
    next_refused = refused;
    if (bus_wr && address_i == REG_STATE_OFS && byteenable_i[0]
        && writedata_i[STATE_REFUSED_POS]) begin
      next_refused = 1'b0;
    end
    if ((cmd_write && state != ST_IDLE) || (state == ST_DECIDE && !cond.legal)) begin
      next_refused = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      refused <= 1'b0;
    end else begin
      refused <= next_refused;
    end
  end

  // ----------------------------------------------------------------
  // Target and duration of the current instruction
  // ----------------------------------------------------------------
  assign offset_ext = {{(PC_WIDTH-7){offset_q[6]}}, offset_q};
  assign is_skip = (op_q == skip_io_set_op) || (op_q == skip_io_clear_op);

  // Branch target is PC plus signed offset plus one; a skip steps over the next
  // instruction, whose length the operand register announces.
  always_comb begin
    next_target = pc_o + PC_WIDTH'(1);
    next_cycles = CYC_NOT_TAKEN;
    if (cond.legal && cond.taken) begin
      if (is_skip) begin
        if (two_word_q) begin
          next_target = pc_o + PC_WIDTH'(3);
          next_cycles = CYC_SKIP_TWO;
        end else begin
          next_target = pc_o + PC_WIDTH'(2);
          next_cycles = CYC_SKIP_ONE;
        end
      end else begin
        next_target = pc_o + offset_ext + PC_WIDTH'(1);
        next_cycles = CYC_TAKEN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The decide cycle is the first cycle of the instruction; any extra cycles are
  // spent in the hold state so the PC moves only at the last one.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cycles_left <= 2'h0;
      pc_target <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_accept) begin
            state <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          pc_target <= next_target;
          cycles_left <= next_cycles - 2'h1;
          if (next_cycles == CYC_NOT_TAKEN) begin
            state <= ST_IDLE;
          end else begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cycles_left <= cycles_left - 2'h1;
          if (cycles_left == 2'h1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Busy covers exactly the cycles the instruction takes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (cmd_accept) begin
      busy_o <= 1'b1;
    end else if ((state == ST_DECIDE && next_cycles == CYC_NOT_TAKEN)
                 || (state == ST_HOLD && cycles_left == 2'h1)) begin
      busy_o <= 1'b0;
    end
  end

  // Outcome and duration are registered at the decide edge and reported from the next cycle onward
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      taken_o <= 1'b0;
      last_cycles <= 2'h0;
    end else if (state == ST_DECIDE) begin
      taken_o <= cond.legal & cond.taken;
      last_cycles <= next_cycles;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  // Reset returns to the program start; software may reposition it while idle.
  // A not-taken instruction advances at the decide edge, others at the last hold edge.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o <= '0;
    end else if (state == ST_DECIDE && next_cycles == CYC_NOT_TAKEN) begin
      pc_o <= next_target;
    end else if (state == ST_HOLD && cycles_left == 2'h1) begin
      pc_o <= pc_target;
    end else if (bus_wr && address_i == REG_PC_OFS && state == ST_IDLE) begin
      pc_o <= (pc_o & ~wmask[PC_WIDTH-1:0]) | (writedata_i[PC_WIDTH-1:0] & wmask[PC_WIDTH-1:0]);
    end
  end

endmodule : branch_skip_unit

// ===== rtl/branch_unit_pkg.sv
// Constants, field layouts and types shared by the conditional branch and skip unit.
// Assumes a single 10 MHz core clock and a byte-addressed Avalon-MM register port.
package branch_unit_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CMD_OFS = 5'h00;
  localparam logic [4:0] REG_OPERAND_OFS = 5'h04;
  localparam logic [4:0] REG_STATUS_OFS = 5'h08;
  localparam logic [4:0] REG_PC_OFS = 5'h0c;
  localparam logic [4:0] REG_STATE_OFS = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_POS = 0;
  localparam int CMD_SEL_POS = 4;
  localparam int OPND_OFFSET_POS = 0;
  localparam int OPND_TWO_WORD_POS = 8;
  localparam int STATE_BUSY_POS = 0;
  localparam int STATE_TAKEN_POS = 1;
  localparam int STATE_REFUSED_POS = 2;
  localparam int STATE_CYCLES_POS = 4;

  // Flag positions inside status_register
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_NEG_POS = 2;
  localparam int FLAG_OVF_POS = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [6:0] OFFSET_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Cycle counts per outcome
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYC_TAKEN = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

  // Instruction codes written into the command register
  typedef enum logic [3:0] {
    skip_io_clear_op = 4'h0,
    skip_io_set_op = 4'h1,
    branch_flag_set_op = 4'h2,
    branch_flag_clear_op = 4'h3,
    branch_carry_clear_op = 4'h4,
    branch_same_higher_op = 4'h5,
    branch_signed_ge_op = 4'h6,
    branch_signed_lt_op = 4'h7
  } op_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DECIDE = 3'b010,
    ST_HOLD = 3'b100
  } state_t;

endpackage : branch_unit_pkg

// ===== testbench/branch_skip_unit_checker.sv
// Port-level assertions for the conditional branch and skip unit.
// Assumes one clock domain and a register port with one wait cycle.
module branch_skip_unit_checker
  import branch_unit_pkg::*;
#(
  parameter int PC_WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bus side
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic waitrequest_o,
  // Core view
  input wire logic [PC_WIDTH-1:0] pc_o,
  input wire logic busy_o,
  input wire logic taken_o
);
  // ----------------------------------------
  // Instruction sequencing and bus handshake
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Work starts only on an accepted command write
  start_on_cmd_a: assert property ($rose(busy_o) |-> $past(write_i) &&
    !$past(waitrequest_o) && $past(address_i) == REG_CMD_OFS) else $error("busy without command");
  busy_bound_a: assert property ($rose(busy_o) |-> ##[1:3] !busy_o)
    else $error("instruction ran too long");
  // A taken outcome keeps busy for a second cycle, a plain one ends at once
  decide_match_a: assert property ($rose(busy_o) |=> busy_o == taken_o)
    else $error("busy and outcome disagree");
  fall_through_a: assert property ($rose(busy_o) ##1 !taken_o |->
    pc_o == $past(pc_o) + 1'b1) else $error("fall through not next word");
  pc_hold_a: assert property ($rose(busy_o) |-> $stable(pc_o) ##1
    (!busy_o || $stable(pc_o))) else $error("pc moved before decide");
  // Outcome may only move in the decide cycle
  taken_when_a: assert property ($changed(taken_o) |-> $past(busy_o) &&
    !$past(busy_o, 2)) else $error("outcome changed outside decide");
  wait_once_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low for more than one cycle");
  answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus request not answered");

  taken_c: cover property ($rose(busy_o) ##1 taken_o);
  plain_c: cover property ($rose(busy_o) ##1 !taken_o);
  long_c: cover property ($rose(busy_o) ##2 busy_o);
endmodule : branch_skip_unit_checker

bind branch_skip_unit branch_skip_unit_checker #(.PC_WIDTH(PC_WIDTH)) checker_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .waitrequest_o(waitrequest_o), .pc_o(pc_o), .busy_o(busy_o),
  .taken_o(taken_o));

// ===== testbench/conditional_branch_skip_unit_bench.sv
// Self-checking bench for the branch and skip unit: bus tasks, scenarios, verdict.
// Assumes the unit answers each bus access after one wait cycle.
module conditional_branch_skip_unit_bench
  import branch_unit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic clk_sys, rst, read, write, waitrequest, busy, taken;
  logic [4:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [7:0] io_reg;
  logic [15:0] pc;
  int fails = 0;
  int comparisons = 0;

  branch_skip_unit #(.PC_WIDTH(16)) DUT (.clk_sys_i(clk_sys), .rst_i(rst), .address_i(address),
    .read_i(read), .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .io_reg_i(io_reg), .pc_o(pc),
    .busy_o(busy), .taken_o(taken));

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One access; an extra edge after release keeps strobes from being set twice at once
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        fails++;
        give_verdict();
      end
      @(posedge clk_sys);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  // Runs one instruction from PC 0x1000 and judges pc, outcome, cycles and flags
  task automatic run(input logic [3:0] op, input logic [2:0] sel, input logic [6:0] k,
                     input logic two, input logic [7:0] st, input logic [7:0] io,
                     input logic take);
    logic [31:0] q;
    logic [15:0] exp;
    logic [1:0] cyc;
    int n;
    n = 0;
    bus(1'b1, REG_STATUS_OFS, {24'h0, st}, q);
    bus(1'b1, REG_OPERAND_OFS, {23'h0, two, 1'b0, k}, q);
    bus(1'b1, REG_PC_OFS, 32'h1000, q);
    io_reg <= io;
    bus(1'b1, REG_CMD_OFS, {25'h0, sel, op}, q);
    while (busy !== 1'b0 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 10) begin
      fails++;
      give_verdict();
    end
    if (!take) exp = 16'h1001;
    else if (op < 4'h2) exp = two ? 16'h1003 : 16'h1002;
    else exp = 16'h1001 + {{9{k[6]}}, k};
    cyc = !take ? 2'h1 : (op < 4'h2 && two) ? 2'h3 : 2'h2;
    chk({16'h0, pc}, {16'h0, exp});
    chk({31'h0, taken}, {31'h0, take});
    bus(1'b0, REG_STATE_OFS, 32'h0, q);
    chk({30'h0, q[5:4]}, {30'h0, cyc});
    bus(1'b0, REG_STATUS_OFS, 32'h0, q);
    chk(q, {24'h0, st});
  endtask : run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset;
    logic [31:0] q;
    chk({16'h0, pc}, 32'h0);
    chk({30'h0, busy, taken}, 32'h0);
    bus(1'b0, REG_STATUS_OFS, 32'h0, q);
    chk(q, {24'h0, STATUS_RESET});
    bus(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    // Byte enables: only the low PC byte lands; a command without byte 0 starts nothing
    byteenable <= 4'h1;
    bus(1'b1, REG_PC_OFS, 32'habcd, q);
    byteenable <= 4'he;
    bus(1'b1, REG_CMD_OFS, 32'h1, q);
    byteenable <= 4'hf;
    chk({31'h0, busy}, 32'h0);
    bus(1'b0, REG_PC_OFS, 32'h0, q);
    chk(q, 32'hcd);
  endtask : sc_reset

  // Every I/O bit, both polarities, one- and two-word followers
  task automatic sc_skip;
    for (int b = 0; b < 8; b++) begin
      run(4'h1, 3'(b), 7'h0, b[0], 8'h1 << b, 8'h1 << b, 1'b1);
      run(4'h1, 3'(b), 7'h0, b[0], 8'h0, ~(8'h1 << b), 1'b0);
      run(4'h0, 3'(b), 7'h0, !b[0], 8'h0, ~(8'h1 << b), 1'b1);
      run(4'h0, 3'(b), 7'h0, 1'b0, 8'h0, 8'h1 << b, 1'b0);
    end
  endtask : sc_skip

  // Every status bit, with only the tested bit set or only it clear
  task automatic sc_flag;
    for (int s = 0; s < 8; s++) begin
      run(4'h2, 3'(s), 7'h05, 1'b0, 8'h1 << s, 8'h0, 1'b1);
      run(4'h2, 3'(s), 7'h05, 1'b0, ~(8'h1 << s), 8'h0, 1'b0);
      run(4'h3, 3'(s), 7'h3f, 1'b0, ~(8'h1 << s), 8'h0, 1'b1);
      run(4'h3, 3'(s), 7'h3f, 1'b0, 8'h1 << s, 8'h0, 1'b0);
    end
  endtask : sc_flag

  // Backward offset; carry clear and same-or-higher share one condition
  task automatic sc_carry;
    for (int c = 0; c < 2; c++) begin
      run(4'h4, 3'h0, 7'h7e, 1'b0, {7'h0, c[0]}, 8'h0, !c[0]);
      run(4'h5, 3'h0, 7'h7e, 1'b0, {7'h7f, c[0]}, 8'h0, !c[0]);
    end
  endtask : sc_carry

  // All four negative/overflow pairs, most negative offset
  task automatic sc_signed;
    logic [7:0] st;
    for (int nv = 0; nv < 4; nv++) begin
      st = {4'h0, nv[1], nv[0], 2'h0};
      run(4'h6, 3'h0, 7'h40, 1'b0, st, 8'h0, !(nv[0] ^ nv[1]));
      run(4'h7, 3'h0, 7'h40, 1'b0, st, 8'h0, nv[0] ^ nv[1]);
    end
  endtask : sc_signed

  // Command during a three-cycle skip is dropped; illegal code falls through
  task automatic sc_refused;
    logic [31:0] q;
    bus(1'b1, REG_OPERAND_OFS, 32'h100, q);
    bus(1'b1, REG_PC_OFS, 32'h1000, q);
    io_reg <= 8'h01;
    bus(1'b1, REG_CMD_OFS, 32'h1, q);
    bus(1'b1, REG_CMD_OFS, 32'h2, q);
    bus(1'b0, REG_STATE_OFS, 32'h0, q);
    chk({31'h0, q[2]}, 32'h1);
    chk({16'h0, pc}, 32'h1003);
    bus(1'b1, REG_STATE_OFS, 32'h4, q);
    bus(1'b0, REG_STATE_OFS, 32'h0, q);
    chk({31'h0, q[2]}, 32'h0);
    run(4'h9, 3'h0, 7'h10, 1'b0, 8'hff, 8'h0, 1'b0);
    // Command and state read back after the illegal code: refused set, one cycle
    bus(1'b0, REG_CMD_OFS, 32'h0, q);
    chk(q, 32'h9);
    bus(1'b0, REG_STATE_OFS, 32'h0, q);
    chk(q, 32'h14);
  endtask : sc_refused

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic give_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    io_reg = 8'h00;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    sc_reset();
    sc_skip();
    sc_flag();
    sc_carry();
    sc_signed();
    sc_refused();
    give_verdict();
  end
endmodule : conditional_branch_skip_unit_bench
